// [design/scm_cfg.svh]
// Constants for the stepper configuration and motion register block
// What this block does
// - Bridge-off bit disables bridge outputs when 1; resets to 1.
// - Decay-path bit: 0 high-side recirculation (default), 1 low-side.
// - Two-bit blank-time code selects 1.0/1.5/2.5/3.5 us; default code 11.
// - Five-bit peak-current code n gives (n+1)*50 mA; reset code 10000.
// - Three-bit select picks what the fault pin shows; default general fault.
// - Open-load level bit picks 13 mA (0, default) or 26 mA threshold.
// - Open-load window code gives 10..40 ms; default code 10.
// - Overcurrent action: 0 retry (default), 1 disable bridge outputs.
// - Overcurrent delay code gives 1..4 us; default code 01.
// - Writing home-reset 1 returns phase and step angle to home.
// - Six-bit signed step delta moves the step angle number by its value.
// - Sleep is entered only on a 0 to 1 change of sleep request.
// - Three-bit microstep code selects resolution; default compensated half.
// - Read-clear inhibit bit 0 lets serial reads clear faults.
// - Finish bit 1 decelerates the running sequence, then halts.
// - Halt-now bit 1 stops the running sequence at once.
// - Stepping sense bit: 0 forward (default), 1 reverse.
// - Step count is 16 bits: low byte register 7, high byte register 8.
// - Run-forever bit 1 runs continuously, ignoring the step count.
// - Six-bit speedup code n gives n*65 full steps per second squared.
// - Six-bit slowdown code n gives -n*65 full steps per second squared.
// - Fault-clear 0 to 1 or reset pin low pulse clears gone faults.
// - With inhibit 0, a read of the status address (F) clears gone faults.
// - Profile commands are taken only while profile-accept is 1.
`ifndef SCM_CFG_SVH
`define SCM_CFG_SVH
`define SCM_ADDR_CURRENT   4'h2
`define SCM_ADDR_MONITOR   4'h3
`define SCM_ADDR_SINGLE    4'h5
`define SCM_ADDR_COMMAND   4'h6
`define SCM_ADDR_TOT_LOW   4'h7
`define SCM_ADDR_TOT_HIGH  4'h8
`define SCM_ADDR_SPEEDUP   4'h9
`define SCM_ADDR_SLOWDOWN  4'hA
`define SCM_ADDR_FAULT_PIN_OUT      4'hF
`define SCM_ADDR_STATUS    4'hF
`define SCM_RST_CURRENT    10'h270
`define SCM_RST_MONITOR    10'h011
`define SCM_RST_SINGLE     10'h000
`define SCM_RST_COMMAND    10'h020
`define SCM_RST_ZERO       10'h000
`define SCM_BIT_WRITE      11
`define SCM_ADDR_HI        15
`define SCM_ADDR_LO        12
`define SCM_CMD_SLEEP      9
`define SCM_CMD_CLEAR      8
`define SCM_CMD_INHIBIT    3
`define SCM_CMD_FINISH     1
`define SCM_CMD_HALT       0
`define SCM_SINGLE_HOME    9
`define SCM_CLK_MHZ        125
`define SCM_STEP_US        1000
`define SCM_STEP_CYC       (`SCM_STEP_US * `SCM_CLK_MHZ)
`endif

// [design/scm_pkg.sv]
// Types shared by the stepper register block
package scm_pkg;
	typedef enum logic [1:0] {
		SCM_IDLE  = 2'b00,
		SCM_RUN   = 2'b01,
		SCM_SLOW  = 2'b10
	} scm_seq_t;
	typedef struct packed {
		logic [15:0] total;
		logic        reverse;
		logic        forever_run;
		logic [5:0]  slow_rate;
	} scm_profile_t;
endpackage

// [design/scm_prof_if.sv]
// Profile hand-off between register file and sequencer
`timescale 1ns/100ps
interface scm_prof_if;
	import scm_pkg::*;
	scm_profile_t prof;
	logic         start;
	logic         finish;
	logic         halt;
	logic         accept;
	logic         active;
	logic         step;
	modport regs (output prof, start, finish, halt, input accept, active, step);
	modport seq  (input prof, start, finish, halt, output accept, active, step);
endinterface

// [design/scm_sequencer.sv]
// Step sequencer that counts steps of a motion profile
`timescale 1ns/100ps
`include "scm_cfg.svh"
module scm_sequencer
	import scm_pkg::*;
#(
	parameter int STEP_CYC = `SCM_STEP_CYC
) (
	// Clock and reset
	input  wire logic clk_sys,
	input  wire logic rst,
	// Profile link
	scm_prof_if.seq   pl
);
	if (STEP_CYC < 2) begin
		$error("STEP_CYC too small");
	end
	scm_seq_t    state;
	logic [31:0] tick;
	logic [15:0] issued;
	logic [15:0] target;
	logic        runf;
	logic [5:0]  slow_left;
	logic        tick_hit;
	assign tick_hit = (tick == 32'(STEP_CYC - 1));
	assign pl.accept = (state == SCM_IDLE);
	assign pl.active = (state != SCM_IDLE);
	always_ff @(posedge clk_sys) begin
		if (rst || state == SCM_IDLE || tick_hit) begin
			tick <= 32'h0;
		end else begin
			tick <= tick + 32'h1;
		end
	end
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			pl.step <= 1'b0;
		end else begin
			pl.step <= tick_hit && state != SCM_IDLE;
		end
	end
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			state     <= SCM_IDLE;
			issued    <= 16'h0;
			target    <= 16'h0;
			runf      <= 1'b0;
			slow_left <= 6'h0;
		end else begin
			unique case (state)
				SCM_IDLE: begin
					if (pl.start) begin
						target    <= pl.prof.total;
						runf      <= pl.prof.forever_run;
						slow_left <= pl.prof.slow_rate;
						issued    <= 16'h0;
						state     <= SCM_RUN;
					end
				end
				SCM_RUN: begin
					if (pl.halt) begin
						state <= SCM_IDLE;
					end else if (pl.finish) begin
						state <= SCM_SLOW;
					end else if (tick_hit) begin
						issued <= issued + 16'h1;
						if (!runf && issued + 16'h1 >= target) begin
							state <= SCM_IDLE;
						end
					end
				end
				SCM_SLOW: begin
					if (pl.halt || slow_left == 6'h0) begin
						state <= SCM_IDLE;
					end else if (tick_hit) begin
						slow_left <= slow_left - 6'h1;
					end
				end
				default: begin
					state <= SCM_IDLE;
				end
			endcase
		end
	end
endmodule

// [design/scm_regs.sv]
// Serial-frame register file for stepper configuration and motion commands
`timescale 1ns/100ps
`include "scm_cfg.svh"
module scm_regs
	import scm_pkg::*;
#(
	parameter int STEP_CYC = `SCM_STEP_CYC
) (
	// Clock and reset
	input  wire logic        clk_sys,
	input  wire logic        rst,
	// Decoded serial frame
	input  wire logic        frame_valid,
	input  wire logic [15:0] frame_data,
	output logic      [15:0] read_data,
	output logic             read_valid,
	// External fault reset pin, active low
	input  wire logic        reset_pin_n,
	// Bridge configuration
	output logic             bridge_off,
	output logic             decay_path_sel,
	output logic             edge_rate_sel,
	output logic      [1:0]  blank_time_sel,
	output logic      [4:0]  peak_current_code,
	// Fault monitor configuration
	output logic      [2:0]  fault_pin_select,
	output logic             openload_level,
	output logic      [1:0]  openload_window,
	output logic             overcurrent_action,
	output logic      [1:0]  overcurrent_delay,
	// Motion and system state
	output logic             home_reset,
	output logic      [5:0]  step_angle,
	output logic      [2:0]  microstep_res,
	output logic             brake_cmd,
	output logic             sleep_enter,
	output logic             fault_clear,
	output logic      [5:0]  speedup_rate,
	output logic      [5:0]  slowdown_rate,
	output logic             reverse_dir,
	output logic             step_pulse,
	output logic             profile_accept,
	output logic             seq_active
);
	scm_prof_if pl();
	scm_sequencer #(.STEP_CYC(STEP_CYC)) u_seq (
		.clk_sys (clk_sys),
		.rst     (rst),
		.pl      (pl)
	);
	logic [9:0]  r_cur;
	logic [9:0]  r_mon;
	logic [9:0]  r_cmd;
	logic [9:0]  r_lo;
	logic [7:0]  r_hi;
	logic [5:0]  r_up;
	logic [5:0]  r_dn;
	logic [1:0]  pin_sync;
	logic        pin_prev;
	logic [3:0]  addr;
	logic [9:0]  wdata;
	logic        wr;
	logic        parity_ok;
	function automatic logic is_addr(input logic [3:0] a, input logic [3:0] b);
		return a == b;
	endfunction
	assign addr      = frame_data[`SCM_ADDR_HI:`SCM_ADDR_LO];
	assign wdata     = frame_data[10:1];
	assign wr        = frame_valid && frame_data[`SCM_BIT_WRITE] && parity_ok;
	assign parity_ok = ~(^frame_data);
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			pin_sync <= 2'b11;
			pin_prev <= 1'b1;
		end else begin
			pin_sync <= {pin_sync[0], reset_pin_n};
			pin_prev <= pin_sync[1];
		end
	end
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			r_cur <= `SCM_RST_CURRENT;
			r_mon <= `SCM_RST_MONITOR;
			r_cmd <= `SCM_RST_COMMAND;
			r_lo  <= `SCM_RST_ZERO;
			r_hi  <= 8'h00;
			r_up  <= 6'h00;
			r_dn  <= 6'h00;
		end else if (wr) begin
			if (is_addr(addr, `SCM_ADDR_CURRENT)) begin
				r_cur <= wdata;
			end
			if (is_addr(addr, `SCM_ADDR_MONITOR)) begin
				r_mon <= wdata;
			end
			if (is_addr(addr, `SCM_ADDR_COMMAND)) begin
				r_cmd <= wdata;
			end
			if (is_addr(addr, `SCM_ADDR_TOT_LOW) && pl.accept) begin
				r_lo <= wdata;
			end
			if (is_addr(addr, `SCM_ADDR_TOT_HIGH) && pl.accept) begin
				r_hi <= wdata[7:0];
			end
			if (is_addr(addr, `SCM_ADDR_SPEEDUP) && pl.accept) begin
				r_up <= wdata[5:0];
			end
			if (is_addr(addr, `SCM_ADDR_SLOWDOWN) && pl.accept) begin
				r_dn <= wdata[5:0];
			end
		end
	end
	// Low byte and flags taken from the frame itself, since r_lo updates on the same edge; high byte and slow rate from r_hi and r_dn
	assign pl.prof = {r_hi, wdata[7:0], wdata[9], wdata[8], r_dn};
	assign pl.start  = wr && is_addr(addr, `SCM_ADDR_TOT_LOW) && pl.accept;
	assign pl.finish = wr && is_addr(addr, `SCM_ADDR_COMMAND) && wdata[`SCM_CMD_FINISH];
	assign pl.halt   = wr && is_addr(addr, `SCM_ADDR_COMMAND) && wdata[`SCM_CMD_HALT];
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			bridge_off         <= 1'b1;
			decay_path_sel     <= 1'b0;
			edge_rate_sel      <= 1'b0;
			blank_time_sel     <= 2'b11;
			peak_current_code  <= 5'h10;
			fault_pin_select   <= 3'h0;
			openload_level     <= 1'b0;
			openload_window    <= 2'b10;
			overcurrent_action <= 1'b0;
			overcurrent_delay  <= 2'b01;
			microstep_res      <= 3'h2;
			brake_cmd          <= 1'b0;
			speedup_rate       <= 6'h00;
			slowdown_rate      <= 6'h00;
			reverse_dir        <= 1'b0;
			step_pulse         <= 1'b0;
			profile_accept     <= 1'b1;
			seq_active         <= 1'b0;
		end else begin
			bridge_off         <= r_cur[9];
			decay_path_sel     <= r_cur[8];
			edge_rate_sel      <= r_cur[7];
			blank_time_sel     <= r_cur[6:5];
			peak_current_code  <= r_cur[4:0];
			fault_pin_select   <= r_mon[9:7];
			openload_level     <= r_mon[5];
			openload_window    <= r_mon[4:3];
			overcurrent_action <= r_mon[2];
			overcurrent_delay  <= r_mon[1:0];
			microstep_res      <= r_cmd[6:4];
			brake_cmd          <= r_cmd[2];
			speedup_rate       <= r_up;
			slowdown_rate      <= r_dn;
			reverse_dir        <= r_lo[9];
			step_pulse         <= pl.step;
			profile_accept     <= pl.accept;
			seq_active         <= pl.active;
		end
	end
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			sleep_enter <= 1'b0;
			fault_clear <= 1'b0;
			home_reset  <= 1'b0;
			step_angle  <= 6'h00;
		end else begin
			sleep_enter <= wr && is_addr(addr, `SCM_ADDR_COMMAND)
				&& wdata[`SCM_CMD_SLEEP] && !r_cmd[`SCM_CMD_SLEEP];
			fault_clear <= (wr && is_addr(addr, `SCM_ADDR_COMMAND)
				&& wdata[`SCM_CMD_CLEAR] && !r_cmd[`SCM_CMD_CLEAR])
				|| (pin_prev && !pin_sync[1])
				|| (frame_valid && !frame_data[`SCM_BIT_WRITE]
				&& is_addr(addr, `SCM_ADDR_STATUS)
				&& !r_cmd[`SCM_CMD_INHIBIT]);
			home_reset  <= wr && is_addr(addr, `SCM_ADDR_SINGLE) && wdata[`SCM_SINGLE_HOME];
			if (wr && is_addr(addr, `SCM_ADDR_SINGLE)) begin
				if (wdata[`SCM_SINGLE_HOME]) begin
					step_angle <= 6'h00;
				end else begin
					step_angle <= step_angle + wdata[5:0];
				end
			end else if (pl.step) begin
				step_angle <= r_lo[9] ? step_angle - 6'h01 : step_angle + 6'h01;
			end
		end
	end
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			read_data  <= 16'h0000;
			read_valid <= 1'b0;
		end else begin
			read_valid <= frame_valid && !frame_data[`SCM_BIT_WRITE];
			read_data  <= 16'h0000;
			if (frame_valid && !frame_data[`SCM_BIT_WRITE]) begin
				unique case (addr)
					`SCM_ADDR_CURRENT:  read_data <= {5'h00, r_cur, 1'b0};
					`SCM_ADDR_MONITOR:  read_data <= {5'h00, r_mon, 1'b0};
					`SCM_ADDR_COMMAND:  read_data <= {5'h00, r_cmd, 1'b0};
					`SCM_ADDR_TOT_LOW:  read_data <= {5'h00, r_lo, 1'b0};
					`SCM_ADDR_TOT_HIGH: read_data <= {7'h00, r_hi, 1'b0};
					`SCM_ADDR_SPEEDUP:  read_data <= {9'h000, r_up, 1'b0};
					`SCM_ADDR_SLOWDOWN: read_data <= {9'h000, r_dn, 1'b0};
					default:            read_data <= {3'h0, pl.accept, pl.active, 11'h000};
				endcase
			end
		end
	end
endmodule

// [tb/scm_regs_checker.sv]
// Port assertions for the register block
`timescale 1ns/100ps
module scm_regs_checker #(
	parameter int STEP_CYC = 4
) (
	// Clock, reset, frames
	input wire logic        clk_sys,
	input wire logic        rst,
	input wire logic        frame_valid,
	input wire logic [15:0] frame_data,
	input wire logic        reset_pin_n,
	// Outputs watched
	input wire logic        bridge_off,
	input wire logic [4:0]  peak_current_code,
	input wire logic [2:0]  microstep_res,
	input wire logic        sleep_enter,
	input wire logic        fault_clear,
	input wire logic        reverse_dir,
	input wire logic        profile_accept,
	input wire logic        seq_active
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);
	wire       good = frame_valid && frame_data[11] && !(^frame_data);
	wire [3:0] adr  = frame_data[15:12];
	wire       cmd  = good && adr == 4'h6;
	chk_bridge_write: assert property (
		good && adr == 4'h2 |-> ##2 bridge_off == $past(frame_data[10], 2))
		else $error("bridge off not stored");
	chk_parity_drop: assert property (
		frame_valid && adr == 4'h2 && (^frame_data) ##1 !frame_valid
		|-> ##1 $stable(peak_current_code))
		else $error("bad parity write taken");
	chk_micro_write: assert property (
		cmd |-> ##2 microstep_res == $past(frame_data[7:5], 2))
		else $error("microstep not stored");
	chk_dir_write: assert property (
		good && adr == 4'h7 && profile_accept |-> ##2 reverse_dir == $past(frame_data[10], 2))
		else $error("direction not stored");
	chk_busy_refuse: assert property (
		frame_valid && adr == 4'h7 && !profile_accept ##1 !frame_valid
		|-> ##1 $stable(reverse_dir))
		else $error("profile taken while busy");
	chk_sleep_repeat: assert property (
		cmd && frame_data[10] ##1 (!frame_valid) [*4] ##1 cmd && frame_data[10]
		|-> ##1 (!sleep_enter) [*4])
		else $error("sleep on repeated request");
	chk_halt_stop: assert property (
		cmd && frame_data[1] |-> ##[1:4] !seq_active)
		else $error("sequence not halted");
	chk_pin_clear: assert property (
		$fell(reset_pin_n) |-> ##[1:6] fault_clear)
		else $error("pin did not clear faults");
endmodule
bind scm_regs scm_regs_checker #(.STEP_CYC(STEP_CYC)) scm_regs_checker_inst (.*);

// [tb/scm_host_model.sv]
// Host model that sends serial frames
`timescale 1ns/100ps
module scm_host_model (
	// Clock and status
	input  wire logic        clk_sys,
	input  wire logic        profile_accept,
	// Frame output
	output logic             frame_valid,
	output logic      [15:0] frame_data
);
	initial begin
		frame_valid = 1'h0;
		frame_data  = 16'h0000;
	end
	// One frame; b inverts the parity bit
	task automatic send(input logic [3:0] a, input logic w, input logic [9:0] d, input logic b);
		logic [15:0] f;
		f = {a, w, d, ^{a, w, d, b}};
		@(posedge clk_sys);
		frame_valid <= 1'h1;
		frame_data  <= f;
		@(posedge clk_sys);
		frame_valid <= 1'h0;
		frame_data  <= ~f;
	endtask
	task automatic wait_ready();
		for (int i = 0; i < 500 && profile_accept !== 1'h1; i++) @(posedge clk_sys);
	endtask
endmodule

// [tb/stepper_config_motion_regs_tb.sv]
// Bench for the stepper register block
`timescale 1ns/100ps
module stepper_config_motion_regs_tb;
	logic        clk_sys, rst, reset_pin_n, frame_valid, read_valid, bridge_off, decay_path_sel;
	logic        edge_rate_sel, openload_level, overcurrent_action, home_reset, brake_cmd, prv;
	logic        sleep_enter, fault_clear, reverse_dir, step_pulse, profile_accept, seq_active;
	logic [15:0] frame_data, read_data, rnd;
	logic [1:0]  blank_time_sel, openload_window, overcurrent_delay;
	logic [2:0]  fault_pin_select, microstep_res;
	logic [3:0]  pat;
	logic [4:0]  peak_current_code;
	logic [5:0]  step_angle, speedup_rate, slowdown_rate, ang;
	int          error_cnt, checks_done, cyc, n_sleep, n_clear, n_step, n_home, s0, s1, e;
	wire  [9:0]  cur_f = {bridge_off, decay_path_sel, edge_rate_sel, blank_time_sel,
		peak_current_code};
	wire  [8:0]  mon_f = {fault_pin_select, openload_level, openload_window, overcurrent_action,
		overcurrent_delay};
	scm_regs #(.STEP_CYC(4)) scm_regs_inst (.*);
	scm_host_model scm_host_model_inst (.*);
	initial begin
		clk_sys = 1'h0;
		forever #4 clk_sys = ~clk_sys;
	end
	always @(posedge clk_sys) begin
		cyc <= cyc + 1;
		n_sleep <= n_sleep + int'(sleep_enter === 1'h1);
		n_clear <= n_clear + int'(fault_clear === 1'h1);
		n_step <= n_step + int'(step_pulse === 1'h1);
		n_home <= n_home + int'(home_reset === 1'h1);
		if (cyc == 12000) begin
			error_cnt++;
			give_verdict();
		end
	end
	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction
	function automatic logic [15:0] mon_exp(input logic [9:0] d);
		return {7'h00, d[9:7], d[5:0]};
	endfunction
	task automatic chk(input string nm, input logic [15:0] x, input logic [15:0] g);
		checks_done++;
		if (g !== x) begin
			error_cnt++;
			$display("BAD %s expected %h seen %h", nm, x, g);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [9:0] d, input logic b);
		scm_host_model_inst.send(a, 1'h1, d, b);
		repeat (3) @(posedge clk_sys);
		#1;
	endtask
	task automatic wait_idle(input int lim);
		for (int i = 0; i < lim && seq_active !== 1'h0; i++) @(posedge clk_sys);
		#1;
	endtask
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	initial begin
		rst = 1'h1;
		reset_pin_n = 1'h1;
		rnd = 16'h002E;
		pat = 4'hB;
		prv = 1'h0;
		repeat (3) @(posedge clk_sys);
		rst <= 1'h0;
		@(posedge clk_sys);
		#1;
		chk("cur", 16'h0270, cur_f);
		chk("mon", 16'h0011, mon_f);
		chk("ms", 16'h0002, microstep_res);
		chk("flags", 16'h0008, {profile_accept, seq_active, reverse_dir, brake_cmd});
		$display("reset test done");
		for (int i = 0; i < 8; i++) begin
			rnd = lfsr(rnd);
			wr(4'h2, rnd[9:0], 1'h0);
			chk("cur", rnd[9:0], cur_f);
			wr(4'h3, rnd[15:6], 1'h0);
			chk("mon", mon_exp(rnd[15:6]), mon_f);
			wr(4'h2, ~rnd[9:0], 1'h1);
			chk("cur", rnd[9:0], cur_f);
		end
		$display("config test done");
		for (int m = 0; m < 8; m++) begin
			wr(4'h6, {3'h0, m[2:0], 1'h0, m[0], 2'h0}, 1'h0);
			chk("ms", m[2:0], microstep_res);
			chk("brake", m[0], brake_cmd);
		end
		s0 = n_sleep;
		s1 = n_clear;
		for (int i = 0; i < 4; i++) begin
			wr(4'h6, {{2{pat[i]}}, 8'h20}, 1'h0);
			e = e + int'(pat[i] & ~prv);
			prv = pat[i];
			chk("sleep", s0 + e, n_sleep);
			chk("clear", s1 + e, n_clear);
		end
		@(posedge clk_sys);
		reset_pin_n <= 1'h0;
		repeat (4) @(posedge clk_sys);
		reset_pin_n <= 1'h1;
		repeat (8) @(posedge clk_sys);
		#1;
		chk("pin", s1 + e + 1, n_clear);
		$display("command test done");
		ang = 6'h3D;
		wr(4'h5, 10'h03D, 1'h0);
		chk("angle", ang, step_angle);
		for (int i = 0; i < 6; i++) begin
			rnd = lfsr(rnd);
			ang = ang + rnd[5:0];
			wr(4'h5, {4'h0, rnd[5:0]}, 1'h0);
			chk("angle", ang, step_angle);
		end
		s0 = n_home;
		wr(4'h5, 10'h200, 1'h0);
		chk("home", s0 + 1, n_home);
		chk("angle", 16'h0000, step_angle);
		$display("single step test done");
		wr(4'h9, 10'h018, 1'h0);
		chk("acc", 16'h0018, speedup_rate);
		wr(4'hA, 10'h03F, 1'h0);
		chk("dec", 16'h003F, slowdown_rate);
		s0 = n_step;
		scm_host_model_inst.wait_ready();
		wr(4'h8, 10'h001, 1'h0);
		wr(4'h7, 10'h202, 1'h0);
		chk("dir", 16'h0001, reverse_dir);
		wait_idle(3000);
		chk("steps", s0 + 258, n_step);
		chk("angle", 16'h003E, step_angle);
		scm_host_model_inst.wait_ready();
		wr(4'h8, 10'h000, 1'h0);
		wr(4'h7, 10'h100, 1'h0);
		repeat (40) @(posedge clk_sys);
		#1;
		chk("run", 16'h0001, seq_active);
		if (profile_accept === 1'h0) begin
			wr(4'h7, 10'h200, 1'h0);
			chk("dir", 16'h0000, reverse_dir);
		end
		s0 = n_step;
		wr(4'h6, 10'h022, 1'h0);
		wait_idle(1000);
		chk("end", 16'h0000, seq_active);
		chk("slow", 16'h0001, 16'(n_step - s0 >= 63 && n_step - s0 <= 66));
		wr(4'h6, 10'h020, 1'h0);
		scm_host_model_inst.wait_ready();
		wr(4'h7, 10'h100, 1'h0);
		wr(4'h6, 10'h021, 1'h0);
		s0 = n_step;
		repeat (20) @(posedge clk_sys);
		#1;
		chk("halt", 16'h0000, {15'h0000, seq_active});
		chk("halted", s0, n_step);
		scm_host_model_inst.send(4'hF, 1'h0, 10'h000, 1'h0);
		#1;
		chk("read", 16'h0001, read_valid);
		chk("status", 16'h1000, read_data);
		s1 = n_clear;
		repeat (3) @(posedge clk_sys);
		#1;
		chk("rdclr", s1 + 1, n_clear);
		wr(4'h6, 10'h028, 1'h0);
		scm_host_model_inst.send(4'h6, 1'h0, 10'h000, 1'h0);
		#1;
		chk("rdback", 16'h0050, read_data);
		s1 = n_clear;
		scm_host_model_inst.send(4'hF, 1'h0, 10'h000, 1'h0);
		repeat (3) @(posedge clk_sys);
		#1;
		chk("inhibit", s1, n_clear);
		$display("motion test done");
		give_verdict();
	end
endmodule
